// *** ocmm_pkg.sv ***
package ocmm_pkg;

   // ----------------------------------------
   // address windows (24-bit byte addresses)
   // ----------------------------------------
   localparam logic [23:0] FL_R1_LO     = 24'hc0_0000;
   localparam logic [23:0] FL_R1_HI     = 24'hc0_efff;
   localparam logic [23:0] FL_CTRL_LO   = 24'hc0_f000;
   localparam logic [23:0] FL_CTRL_HI   = 24'hc0_ffff;
   localparam logic [23:0] FL_R2_LO     = 24'hc1_0000;
   localparam logic [23:0] FL_R2_HI_320 = 24'hc4_ffff;
   localparam logic [23:0] FL_R2_HI_192 = 24'hc1_ffff;
   localparam logic [23:0] FL_R3_LO_192 = 24'hc4_0000;
   localparam logic [23:0] FL_R3_HI_192 = 24'hc4_ffff;
   localparam logic [23:0] FL_M1_BASE   = 24'hc4_0000;
   localparam logic [23:0] PROGRAM_SRAM_BASE   = 24'he0_0000;
   localparam logic [23:0] DATA_SRAM_TOP    = 24'h00_dfff;
   localparam logic [23:0] DUAL_PORT_RAM_BASE   = 24'h00_f600;
   localparam logic [23:0] DUAL_PORT_RAM_HI     = 24'h00_fdff;
   localparam logic [23:0] SFR_BASE     = 24'h00_fe00;
   localparam logic [23:0] SFR_HI       = 24'h00_ffff;
   localparam logic [23:0] EXTENDED_FUNCTION_REG_SPACE_BASE    = 24'h00_f000;
   localparam logic [23:0] EXTENDED_FUNCTION_REG_SPACE_HI      = 24'h00_f1ff;

   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int          FL_BIG_KB      = 320;
   localparam int          FL_SMALL_KB    = 192;
   localparam int          SECTOR_SHIFT   = 12;
   localparam int          BLOCK_SHIFT    = 7;
   localparam int          LINE_SHIFT     = 4;
   localparam int          LINE_BITS      = 128;
   localparam int          CHECK_BITS     = 8;
   localparam logic [23:0] DUAL_PORT_RAM_BIT_BASE = 24'h00_0700;
   localparam logic [1:0]  PW_IDLE        = 2'h0;
   localparam logic [1:0]  PW_FIRST_OK    = 2'h1;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      TGT_NONE, TGT_FLASH, TGT_PROGRAM_SRAM, TGT_DATA_SRAM, TGT_DUAL_PORT_RAM, TGT_SFR, TGT_EXTENDED_FUNCTION_REG_SPACE, TGT_CTRL
   } ocmm_tgt_t;

   typedef enum logic [1:0] {
      OP_READ, OP_WRITE, OP_ERASE, OP_PROGRAM
   } ocmm_op_t;

   typedef struct packed {
      ocmm_tgt_t   target;
      logic [23:0] offset;
      logic        module_sel;
   } ocmm_dec_t;

   typedef struct packed {
      logic                  valid;
      ocmm_tgt_t             target;
      ocmm_op_t              op;
      logic                  err;
      logic [23:0]           offset;
      logic                  module_sel;
      logic                  bit_ok;
      logic [1:0]            pw_stage;
      logic                  unlocked;
      logic [1:0]            rvalid;
      logic [1:0]            corrected;
      logic [1:0][127:0]     rdata;
   } ocmm_state_t;

endpackage

// *** ocmm_map.sv ***
`timescale 1ns/1ps
// Behaviour
// - flash mapped as discontinuous variant-specific ranges
// - flash split into two modules at FL_M1_BASE in both variants
// - top 4 KB sector reserved, not user-mapped
// - program sram grows up from base
// - data sram grows down from window top
// - register bank: sixteen words, eight byte pairs
// - top 256 dual-port bytes bit addressable
// - two 512-byte register spaces mapped
// - flash modules use uniform 4 KB sectors
// - per-sector erase, 128-byte program blocks
// - read protection, password sequence unlocks
// - flash read returns 128-bit lines
// - error correction on every flash read
// - two flash modules serve requests independently
// - sectors clustered for write protection bits
module ocmm_map #(
   parameter int          FLASH_KB        = 320,
   parameter int          PROGRAM_SRAM_BYTES     = 16384,
   parameter int          DATA_SRAM_BYTES     = 16384,
   parameter int          CLUSTER_SECTORS = 4,
   parameter logic [15:0] PASSWORD_0      = 16'h5a5a, // arbitrary value
   parameter logic [15:0] PASSWORD_1      = 16'ha5a5  // arbitrary value
) (
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_arst_n,
   // cpu request
   input  wire logic                  i_req,
   input  wire logic [23:0]           i_addr,
   input  wire ocmm_pkg::ocmm_op_t    i_op,
   output logic                       o_ready,
   // general register access
   input  wire logic                  i_gr_access,
   input  wire logic [23:0]           i_gr_base,
   input  wire logic [3:0]            i_gr_num,
   input  wire logic                  i_gr_byte,
   input  wire logic                  i_gr_high,
   // flash protection
   input  wire logic                  i_read_protect,
   input  wire logic [1:0][15:0]      i_wprot,
   input  wire logic                  i_pw_strobe,
   input  wire logic [15:0]           i_pw_word,
   input  wire logic                  i_relock,
   input  wire logic [1:0]            i_fl_busy,
   // decoded access
   output logic                       o_valid,
   output ocmm_pkg::ocmm_tgt_t        o_target,
   output ocmm_pkg::ocmm_op_t         o_op,
   output logic                       o_err,
   output logic [23:0]                o_offset,
   output logic                       o_module,
   output logic [5:0]                 o_sector,
   output logic [3:0]                 o_cluster,
   output logic [10:0]                o_block,
   output logic [13:0]                o_line,
   output logic                       o_bit_ok,
   output logic                       o_unlocked,
   // flash read return
   input  wire logic [1:0]            i_fl_rvalid,
   input  wire logic [1:0][127:0]     i_fl_rdata,
   input  wire logic [1:0][7:0]       i_fl_rcheck,
   output logic [1:0]                 o_fl_rvalid,
   output logic [1:0][127:0]          o_fl_rdata,
   output logic [1:0]                 o_fl_corrected
);

   if (!(FLASH_KB == ocmm_pkg::FL_BIG_KB || FLASH_KB == ocmm_pkg::FL_SMALL_KB)) begin : g_bad_kb
      $error("FLASH_KB must be 320 or 192");
   end
   if (PROGRAM_SRAM_BYTES < 1 || PROGRAM_SRAM_BYTES > 65536
       || DATA_SRAM_BYTES < 1 || DATA_SRAM_BYTES > 16384) begin : g_bad_ram
      $error("sram size out of range");
   end
   if (CLUSTER_SECTORS != 4) begin : g_bad_cl
      $error("cluster size must be 4 sectors");
   end

   localparam logic [23:0] PROGRAM_SRAM_HI = ocmm_pkg::PROGRAM_SRAM_BASE + 24'(PROGRAM_SRAM_BYTES - 1);
   localparam logic [23:0] DATA_SRAM_LO = ocmm_pkg::DATA_SRAM_TOP - 24'(DATA_SRAM_BYTES - 1);
   localparam bit          BIG      = (FLASH_KB == ocmm_pkg::FL_BIG_KB);

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic ocmm_pkg::ocmm_dec_t decode(input logic [23:0] a);
      ocmm_pkg::ocmm_dec_t d;
      logic                fl;
      d = '{target: ocmm_pkg::TGT_NONE, offset: 24'h0, module_sel: 1'b0};
      fl = (a >= ocmm_pkg::FL_R1_LO && a <= ocmm_pkg::FL_R1_HI)
         || (BIG && a >= ocmm_pkg::FL_R2_LO && a <= ocmm_pkg::FL_R2_HI_320)
         || (!BIG && a >= ocmm_pkg::FL_R2_LO && a <= ocmm_pkg::FL_R2_HI_192)
         || (!BIG && a >= ocmm_pkg::FL_R3_LO_192 && a <= ocmm_pkg::FL_R3_HI_192);
      if (a >= ocmm_pkg::FL_CTRL_LO && a <= ocmm_pkg::FL_CTRL_HI) begin
         d.target = ocmm_pkg::TGT_CTRL;
         d.offset = a - ocmm_pkg::FL_R1_LO;
      end else if (fl) begin
         d.target = ocmm_pkg::TGT_FLASH;
         if (a >= ocmm_pkg::FL_M1_BASE) begin
            d.module_sel = 1'b1;
            d.offset     = a - ocmm_pkg::FL_M1_BASE;
         end else begin
            d.offset = a - ocmm_pkg::FL_R1_LO;
         end
      end else if (a >= ocmm_pkg::PROGRAM_SRAM_BASE && a <= PROGRAM_SRAM_HI) begin
         d.target = ocmm_pkg::TGT_PROGRAM_SRAM;
         d.offset = a - ocmm_pkg::PROGRAM_SRAM_BASE;
      end else if (a >= DATA_SRAM_LO && a <= ocmm_pkg::DATA_SRAM_TOP) begin
         d.target = ocmm_pkg::TGT_DATA_SRAM;
         d.offset = a - DATA_SRAM_LO;
      end else if (a >= ocmm_pkg::DUAL_PORT_RAM_BASE && a <= ocmm_pkg::DUAL_PORT_RAM_HI) begin
         d.target = ocmm_pkg::TGT_DUAL_PORT_RAM;
         d.offset = a - ocmm_pkg::DUAL_PORT_RAM_BASE;
      end else if (a >= ocmm_pkg::SFR_BASE && a <= ocmm_pkg::SFR_HI) begin
         d.target = ocmm_pkg::TGT_SFR;
         d.offset = a - ocmm_pkg::SFR_BASE;
      end else if (a >= ocmm_pkg::EXTENDED_FUNCTION_REG_SPACE_BASE && a <= ocmm_pkg::EXTENDED_FUNCTION_REG_SPACE_HI) begin
         d.target = ocmm_pkg::TGT_EXTENDED_FUNCTION_REG_SPACE;
         d.offset = a - ocmm_pkg::EXTENDED_FUNCTION_REG_SPACE_BASE;
      end
      return d;
   endfunction

   // general register slot inside the bank: words 0..15, bytes only for 0..7
   function automatic logic [23:0] gr_addr(input logic [23:0] base, input logic [3:0] n,
                                           input logic byte_mode, input logic high);
      logic [23:0] a;
      a = base + {19'h0, n, 1'b0};
      if (byte_mode) begin
         a = base + {19'h0, 1'b0, n[2:0], high};
      end
      return a;
   endfunction

   // ----------------------------------------
   // single-error correction over a 128-bit line
   // ----------------------------------------
   // check bit k sits at hamming position 2**k; data fills the others from 3
   function automatic logic [7:0] ecc_syn(input logic [127:0] d, input logic [7:0] c);
      logic [7:0] s;
      logic [8:0] p;
      s = c;
      p = 9'd3;
      for (int i = 0; i < ocmm_pkg::LINE_BITS; i++) begin
         if ((p & (p - 9'd1)) == 9'd0) begin
            p = p + 9'd1;
         end
         if (d[i]) begin
            s = s ^ p[7:0];
         end
         p = p + 9'd1;
      end
      return s;
   endfunction

   function automatic logic [127:0] ecc_fix(input logic [127:0] d, input logic [7:0] s);
      logic [127:0] r;
      logic [8:0]   p;
      r = d;
      p = 9'd3;
      for (int i = 0; i < ocmm_pkg::LINE_BITS; i++) begin
         if ((p & (p - 9'd1)) == 9'd0) begin
            p = p + 9'd1;
         end
         if (p[7:0] == s) begin
            r[i] = ~d[i];
         end
         p = p + 9'd1;
      end
      return r;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   ocmm_pkg::ocmm_state_t st;
   ocmm_pkg::ocmm_state_t next_st;
   ocmm_pkg::ocmm_dec_t   dec;
   logic [23:0]           eff_addr;
   logic                  gr_bad;
   logic [3:0]            cl;

   assign eff_addr = i_gr_access ? gr_addr(i_gr_base, i_gr_num, i_gr_byte, i_gr_high) : i_addr;
   assign dec      = decode(eff_addr);
   assign gr_bad   = i_gr_access && ((i_gr_byte && i_gr_num[3])
                   || dec.target != ocmm_pkg::TGT_DUAL_PORT_RAM);
   assign cl       = dec.offset[17:14];

   // a busy module stalls only requests aimed at itself
   assign o_ready  = !(dec.target == ocmm_pkg::TGT_FLASH && i_fl_busy[dec.module_sel]);

   always_comb begin
      logic prot_w;
      prot_w  = i_wprot[dec.module_sel][cl] && !st.unlocked;
      next_st = st;
      next_st.valid = 1'b0;
      if (i_req && o_ready) begin
         next_st.valid      = 1'b1;
         next_st.target     = dec.target;
         next_st.op         = i_op;
         next_st.offset     = dec.offset;
         next_st.module_sel = dec.module_sel;
         next_st.bit_ok     = i_gr_access || (dec.target == ocmm_pkg::TGT_DUAL_PORT_RAM
                              && dec.offset >= ocmm_pkg::DUAL_PORT_RAM_BIT_BASE);
         next_st.err        = gr_bad;
         case (dec.target)
            ocmm_pkg::TGT_FLASH: begin
               case (i_op)
                  ocmm_pkg::OP_READ: begin
                     if (i_read_protect && !st.unlocked) begin
                        next_st.err = 1'b1;
                     end
                  end
                  ocmm_pkg::OP_ERASE: begin
                     if (prot_w) begin
                        next_st.err = 1'b1;
                     end
                  end
                  ocmm_pkg::OP_PROGRAM: begin
                     if (prot_w || dec.offset[ocmm_pkg::BLOCK_SHIFT-1:0] != 7'h00) begin
                        next_st.err = 1'b1;
                     end
                  end
                  default: begin
                     next_st.err = 1'b1;
                  end
               endcase
            end
            ocmm_pkg::TGT_NONE, ocmm_pkg::TGT_CTRL: begin
               next_st.err = 1'b1;
            end
            default: begin
               if (i_op == ocmm_pkg::OP_ERASE || i_op == ocmm_pkg::OP_PROGRAM) begin
                  next_st.err = 1'b1;
               end
            end
         endcase
      end

      // password: two consecutive matching words unlock
      if (i_relock) begin
         next_st.unlocked = 1'b0;
      end
      if (i_pw_strobe) begin
         next_st.pw_stage = ocmm_pkg::PW_IDLE;
         if (st.pw_stage == ocmm_pkg::PW_IDLE && i_pw_word == PASSWORD_0) begin
            next_st.pw_stage = ocmm_pkg::PW_FIRST_OK;
         end else if (st.pw_stage == ocmm_pkg::PW_FIRST_OK && i_pw_word == PASSWORD_1) begin
            next_st.unlocked = 1'b1;
         end
      end

      // read return per module, each independent
      for (int m = 0; m < 2; m++) begin
         logic [7:0] s;
         s = ecc_syn(i_fl_rdata[m], i_fl_rcheck[m]);
         next_st.rvalid[m]    = i_fl_rvalid[m];
         next_st.corrected[m] = 1'b0;
         if (i_fl_rvalid[m]) begin
            next_st.rdata[m]     = ecc_fix(i_fl_rdata[m], s);
            next_st.corrected[m] = (s != 8'h00);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_valid        = st.valid;
   assign o_target       = st.target;
   assign o_op           = st.op;
   assign o_err          = st.err;
   assign o_offset       = st.offset;
   assign o_module       = st.module_sel;
   assign o_sector       = st.offset[17:ocmm_pkg::SECTOR_SHIFT];
   assign o_cluster      = st.offset[17:14];
   assign o_block        = st.offset[17:ocmm_pkg::BLOCK_SHIFT];
   assign o_line         = st.offset[17:ocmm_pkg::LINE_SHIFT];
   assign o_bit_ok       = st.bit_ok;
   assign o_unlocked     = st.unlocked;
   assign o_fl_rvalid    = st.rvalid;
   assign o_fl_rdata     = st.rdata;
   assign o_fl_corrected = st.corrected;

endmodule

// *** ocmm_map_asserts.sv ***
`timescale 1ns/1ps
module ocmm_map_asserts #(
   parameter logic [15:0] PASSWORD_0 = 16'h5a5a,
   parameter logic [15:0] PASSWORD_1 = 16'ha5a5
) (
   // clock and reset
   input wire logic                i_clk,
   input wire logic                i_arst_n,
   // request and decode
   input wire logic                i_req,
   input wire logic                o_ready,
   input wire logic [1:0]          i_fl_busy,
   input wire logic                o_valid,
   input wire ocmm_pkg::ocmm_tgt_t o_target,
   input wire ocmm_pkg::ocmm_op_t  o_op,
   input wire logic                o_err,
   input wire logic [23:0]         o_offset,
   input wire logic [5:0]          o_sector,
   input wire logic [13:0]         o_line,
   // password and read return
   input wire logic                i_pw_strobe,
   input wire logic [15:0]         i_pw_word,
   input wire logic                o_unlocked,
   input wire logic [1:0]          i_fl_rvalid,
   input wire logic [1:0]          o_fl_rvalid,
   input wire logic [1:0]          o_fl_corrected
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);
   logic fl_v;
   assign fl_v = o_valid && o_target == ocmm_pkg::TGT_FLASH;
   take_valid_a: assert property (i_req && o_ready |=> o_valid)
      else $error("taken request gave no pulse");
   valid_cause_a: assert property (o_valid |-> $past(i_req && o_ready))
      else $error("pulse without taken request");
   ready_busy_a: assert property (!o_ready |-> i_fl_busy != 2'h0)
      else $error("ready low with no busy module");
   ctrl_err_a: assert property (o_valid && o_target == ocmm_pkg::TGT_CTRL |-> o_err)
      else $error("control sector not flagged");
   flash_write_a: assert property (fl_v && o_op == ocmm_pkg::OP_WRITE |-> o_err)
      else $error("flash write not flagged");
   prog_align_a: assert property (fl_v && o_op == ocmm_pkg::OP_PROGRAM
      && o_offset[6:0] != 7'h00 |-> o_err) else $error("unaligned program not flagged");
   field_slices_a: assert property (o_sector == o_offset[17:12]
      && o_line == o_offset[17:4] && !(fl_v && o_offset[23:18] != 6'h00))
      else $error("sector or line slice wrong");
   rvalid_follow_a: assert property (o_fl_rvalid == $past(i_fl_rvalid))
      else $error("read return not one cycle later");
   corr_pulse_a: assert property ((o_fl_corrected & ~o_fl_rvalid) == 2'h0)
      else $error("corrected flag outside return");
   unlock_seq_a: assert property (i_pw_strobe && i_pw_word == PASSWORD_1
      && $past(i_pw_strobe && i_pw_word == PASSWORD_0) && !$past(i_pw_strobe, 2)
      |=> o_unlocked) else $error("password pair did not unlock");
   cover property (fl_v && !o_err);
   cover property (o_fl_corrected != 2'h0);
   cover property ($rose(o_unlocked));
   cover property (i_req && !o_ready);
endmodule
bind ocmm_map ocmm_map_asserts #(.PASSWORD_0(PASSWORD_0), .PASSWORD_1(PASSWORD_1)) i_chk (
   .i_clk, .i_arst_n, .i_req, .o_ready, .i_fl_busy, .o_valid, .o_target, .o_op, .o_err,
   .o_offset, .o_sector, .o_line, .i_pw_strobe, .i_pw_word, .o_unlocked, .i_fl_rvalid,
   .o_fl_rvalid, .o_fl_corrected);

// *** ocmm_flash_model.sv ***
`timescale 1ns/1ps
module ocmm_flash_model (
   // command from bench
   input  wire logic         i_clk,
   input  wire logic [1:0]   i_go,
   input  wire logic [127:0] i_data,
   input  wire logic [7:0]   i_flip,
   // line return per module
   output logic [1:0]        o_rvalid,
   output logic [1:0][127:0] o_rdata,
   output logic [1:0][7:0]   o_rcheck
);
   function automatic logic [7:0] chk(input logic [127:0] d);
      int         p;
      logic [7:0] c;
      c = 8'h00;
      p = 2;
      for (int i = 0; i < 128; i++) begin
         p++;
         if ((p & (p - 1)) == 0) p++;
         if (d[i]) c ^= p[7:0];
      end
      return c;
   endfunction
   initial {o_rvalid, o_rdata, o_rcheck} = '0;
   // both modules answer on their own, even in the same cycle
   always @(posedge i_clk) begin
      for (int m = 0; m < 2; m++) begin
         o_rvalid[m] <= i_go[m];
         if (i_go[m]) begin
            // whole 128-bit line, bit 7 of flip means no fault
            o_rdata[m] <= i_data ^ (i_flip[7] ? 128'h0 : 128'h1 << i_flip[6:0]);
            o_rcheck[m] <= chk(i_data);
         end else begin
            // idle lines toggle so stale data never looks valid
            o_rdata[m] <= ~o_rdata[m];
            o_rcheck[m] <= ~o_rcheck[m];
         end
      end
   end
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
   localparam logic [15:0] PW0 = 16'h5a5a; // arbitrary
   localparam logic [15:0] PW1 = 16'ha5a5; // arbitrary
   logic                i_clk = 1'b0;
   logic                i_arst_n, i_req, i_gr_access, i_gr_byte, i_gr_high, unl;
   logic                i_read_protect, i_pw_strobe, i_relock, o_ready, o_valid, o_err;
   logic                o_module, o_bit_ok, o_unlocked;
   logic [23:0]         i_addr, i_gr_base, o_offset;
   logic [15:0]         i_pw_word, r;
   logic [13:0]         o_line;
   logic [10:0]         o_block;
   logic [7:0]          flip;
   logic [5:0]          o_sector;
   logic [3:0]          i_gr_num, o_cluster;
   logic [1:0]          i_fl_busy, go, g, rv, o_fl_rvalid, o_fl_corrected;
   logic [1:0][15:0]    i_wprot;
   logic [1:0][7:0]     rc;
   logic [1:0][127:0]   rd, o_fl_rdata;
   logic [127:0]        data;
   ocmm_pkg::ocmm_op_t  i_op, o_op;
   ocmm_pkg::ocmm_tgt_t o_target;
   int                  err_total = 0;
   int                  checked = 0;
   // window end addresses, tried with every op and later with random offsets of -64 to +63
   logic [23:0]         edges [16] = '{24'hc0_efff, 24'hc0_f000, 24'hc0_ffff, 24'hc1_0000,
      24'hc3_ffff, 24'hc4_ffff, 24'hc5_0000, 24'he0_3fff, 24'he0_4000, 24'h00_9fff,
      24'h00_a000, 24'h00_f5ff, 24'h00_fdff, 24'h00_fe00, 24'h00_f1ff, 24'h00_f200};
   ocmm_map #(.PASSWORD_0(PW0), .PASSWORD_1(PW1)) i_dut (.i_clk, .i_arst_n, .i_req, .i_addr,
      .i_op, .o_ready, .i_gr_access, .i_gr_base, .i_gr_num, .i_gr_byte, .i_gr_high,
      .i_read_protect, .i_wprot, .i_pw_strobe, .i_pw_word, .i_relock, .i_fl_busy, .o_valid,
      .o_target, .o_op, .o_err, .o_offset, .o_module, .o_sector, .o_cluster, .o_block,
      .o_line, .o_bit_ok, .o_unlocked, .i_fl_rvalid(rv), .i_fl_rdata(rd), .i_fl_rcheck(rc),
      .o_fl_rvalid, .o_fl_rdata, .o_fl_corrected);
   ocmm_flash_model i_flash (.i_clk, .i_go(go), .i_data(data), .i_flip(flip),
      .o_rvalid(rv), .o_rdata(rd), .o_rcheck(rc));
   always #5 i_clk = ~i_clk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [3:0] exp_dec(input logic [23:0] a, input ocmm_pkg::ocmm_op_t op);
      ocmm_pkg::ocmm_tgt_t t;
      logic                m;
      logic                e;
      logic [23:0]         off;
      m = a >= 24'hc4_0000;
      off = a - (m ? 24'hc4_0000 : 24'hc0_0000);
      if (a inside {[24'hc0_0000:24'hc0_efff], [24'hc1_0000:24'hc4_ffff]}) t = ocmm_pkg::TGT_FLASH;
      else if (a inside {[24'hc0_f000:24'hc0_ffff]}) t = ocmm_pkg::TGT_CTRL;
      else if (a inside {[24'he0_0000:24'he0_3fff]}) t = ocmm_pkg::TGT_PROGRAM_SRAM;
      else if (a inside {[24'h00_a000:24'h00_dfff]}) t = ocmm_pkg::TGT_DATA_SRAM;
      else if (a inside {[24'h00_f600:24'h00_fdff]}) t = ocmm_pkg::TGT_DUAL_PORT_RAM;
      else if (a inside {[24'h00_fe00:24'h00_ffff]}) t = ocmm_pkg::TGT_SFR;
      else if (a inside {[24'h00_f000:24'h00_f1ff]}) t = ocmm_pkg::TGT_EXTENDED_FUNCTION_REG_SPACE;
      else t = ocmm_pkg::TGT_NONE;
      e = t inside {ocmm_pkg::TGT_NONE, ocmm_pkg::TGT_CTRL} || op >= ocmm_pkg::OP_ERASE;
      if (t == ocmm_pkg::TGT_FLASH)
         e = op == ocmm_pkg::OP_WRITE || (op == ocmm_pkg::OP_READ && i_read_protect && !unl)
            || (op >= ocmm_pkg::OP_ERASE && i_wprot[m][off[17:14]] && !unl)
            || (op == ocmm_pkg::OP_PROGRAM && off[6:0] != 7'h00);
      return {t, e};
   endfunction
   task automatic tick();
      @(posedge i_clk);
      #1;
   endtask
   task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // request stays high, so successive calls run back to back
   task automatic access(input logic [23:0] a, input ocmm_pkg::ocmm_op_t op);
      logic [3:0]  e;
      logic [23:0] off;
      e = exp_dec(a, op);
      off = a - (a >= 24'hc4_0000 ? 24'hc4_0000 : 24'hc0_0000);
      {i_gr_access, i_req, i_addr} = {2'b01, a};
      i_op = op;
      tick();
      check("valid", o_valid, 1'b1);
      check("target_err", {o_target, o_err}, e);
      check("op", o_op, op);
      if (e[3:1] == ocmm_pkg::TGT_FLASH) begin
         check("module_offset", {o_module, o_offset}, {a >= 24'hc4_0000, off});
         check("sector", {o_sector, o_cluster}, {off[17:12], off[17:14]});
         check("block", o_block, off[17:7]);
         check("line", o_line, off[17:4]);
      end
      if (e[3:1] == ocmm_pkg::TGT_DUAL_PORT_RAM) check("bit_ok", o_bit_ok, a >= 24'h00_fd00);
   endtask
   task automatic gr(input logic [3:0] n, input logic b);
      {i_gr_access, i_req, i_gr_base} = {2'b11, 24'h00_f600};
      {i_gr_num, i_gr_byte, i_gr_high} = {n, b, n[0]};
      i_op = ocmm_pkg::OP_READ;
      tick();
      check("gr_err", o_err, b && n[3]);
      if (!(b && n[3])) begin
         check("gr_bit", {o_target, o_bit_ok}, {ocmm_pkg::TGT_DUAL_PORT_RAM, 1'b1});
         check("gr_off", o_offset, b ? 24'(2 * n[2:0] + n[0]) : 24'(2 * n));
      end
   endtask
   task automatic pw(input logic [15:0] w);
      {i_pw_strobe, i_pw_word} = {1'b1, w};
      tick();
   endtask
   initial begin
      {i_arst_n, i_req, i_gr_access, i_gr_byte, i_gr_high, unl, i_read_protect, i_relock} = '0;
      {i_pw_strobe, i_addr, i_gr_base, i_gr_num, i_pw_word, i_fl_busy, go, i_wprot, data} = '0;
      flip = 8'h80;
      r = 16'h0013;
      i_op = ocmm_pkg::OP_READ;
      repeat (8) @(posedge i_clk);
      #1;
      i_arst_n = 1'b1;
      check("reset", {o_valid, o_target, o_unlocked}, 5'h00);
      foreach (edges[i])
         for (int o = 0; o < 4; o++) access(edges[i], ocmm_pkg::ocmm_op_t'(o[1:0]));
      for (int n = 0; n < 32; n++) gr(n[3:0], n[4]);
      i_req = 1'b0;
      pw(PW0);
      pw(16'h0f0f);
      i_pw_strobe = 1'b0;
      tick();
      check("locked", o_unlocked, 1'b0);
      pw(PW0);
      i_relock = 1'b1;
      pw(PW1);
      check("unlock", o_unlocked, 1'b1);
      {i_pw_strobe, i_relock, i_read_protect, unl, i_wprot} = {4'h3, 32'hffff_ffff};
      access(24'hc1_0000, ocmm_pkg::OP_PROGRAM);
      access(24'hc0_2000, ocmm_pkg::OP_READ);
      {i_req, i_relock} = 2'b01;
      tick();
      {i_relock, unl} = 2'b00;
      check("relock", o_unlocked, 1'b0);
      access(24'hc0_2000, ocmm_pkg::OP_READ);
      for (int k = 0; k < 300; k++) begin
         r = lfsr(r);
         {i_read_protect, i_wprot} = {r[13], r, ~r};
         access(edges[r[3:0]] + {17'h0, r[10:4]} - 24'h40, ocmm_pkg::ocmm_op_t'(r[12:11]));
      end
      {i_fl_busy, i_addr} = {2'b10, 24'hc4_0100};
      #1;
      check("ready", o_ready, 1'b0);
      tick();
      check("refused", o_valid, 1'b0);
      access(24'hc0_0100, ocmm_pkg::OP_READ);
      {i_fl_busy, i_req} = 3'h0;
      for (int k = 0; k < 12; k++) begin
         r = lfsr(r);
         data = {r, ~r, r, r, ~r, r, r, r} ^ 128'(k);
         flip = k < 2 ? {1'b0, {7{k[0]}}} : {r[15], r[6:0]};
         g = k == 2 ? 2'b11 : {r[8], ~r[8]};
         go = g;
         tick();
         go = 2'b00;
         tick();
         check("rvalid", {o_fl_rvalid, o_fl_corrected}, {g, flip[7] ? 2'b00 : g});
         for (int m = 0; m < 2; m++)
            if (g[m]) check("rdata", o_fl_rdata[m], data);
      end
      final_report();
   end
   // the run needs about 500 cycles; this leaves ample margin
   initial begin
      #60000;
      err_total++;
      final_report();
   end
endmodule
